// ==== verilog/led_defines.svh ====
`ifndef LED_DEFINES_SVH
`define LED_DEFINES_SVH

// ----------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------
// System clock rate in Hz
`define LED_CLK_HZ 40000000
// Clock cycles per millisecond
`define LED_CYC_PER_MS (`LED_CLK_HZ / 1000)
// Start-up watchdog time in minutes
`define LED_HANG_TIME_MIN 3
// Start-up watchdog time in cycles, 64-bit because it passes 2**31
`define LED_HANG_CYCLES (64'd60 * `LED_HANG_TIME_MIN * `LED_CLK_HZ)
// Flash half periods in milliseconds (slow 0.5 Hz, fast 2 Hz, var 1 Hz)
`define LED_SLOW_HALF_MS 1000
`define LED_FAST_HALF_MS 250
`define LED_VAR_HALF_MS 500

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define LED_CONFIG_OFS 12'h000
`define LED_SLOW_OFS 12'h004
`define LED_FAST_OFS 12'h008
`define LED_VAR_OFS 12'h00C
`define LED_STATUS_OFS 12'h010

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define LED_CFG_BUS_LSB 0
`define LED_CFG_MON_BIT 2
`define LED_CFG_SAVE_BIT 3
// Reset: industrial Ethernet, monitoring on, no save/restore
`define LED_CONFIG_RST 4'h4
`define LED_ST_RUN_BIT 0
`define LED_ST_BOOTF_BIT 1
`define LED_ST_MOTOR_BIT 2
`define LED_ST_FACT_BIT 3
`define LED_ST_HANG_BIT 4
`define LED_ST_RDY_LSB 8
`define LED_ST_BF_LSB 10
`define LED_ST_LNK_BIT 12
// Consecutive hung boots that raise the boot failure fault
`define LED_BOOT_FAIL_TRIES 4'h3

`endif

// ==== verilog/led_pkg.sv ====
package led_pkg;

  // ----------------------------------------------------------------
  // Indicator patterns and colours
  // ----------------------------------------------------------------
  // Signal state of one indicator
  typedef enum logic [2:0] {
    PAT_OFF = 3'h0,
    PAT_ON = 3'h1,
    PAT_SLOW = 3'h2,
    PAT_FAST = 3'h3,
    PAT_VAR = 3'h4
  } pattern_t;

  // Colour as {green, red}; orange and yellow light both dies
  typedef enum logic [1:0] {
    COL_NONE = 2'h0,
    COL_RED = 2'h1,
    COL_GREEN = 2'h2,
    COL_ORANGE = 2'h3
  } colour_t;

  // Fieldbus in use
  typedef enum logic [1:0] {
    BUS_ETH = 2'h0,
    BUS_RS485 = 2'h1,
    BUS_TOKEN = 2'h2,
    BUS_NONE = 2'h3
  } fieldbus_t;

  // Start-up sequence, Gray along boot to run
  typedef enum logic [1:0] {
    ST_BOOT = 2'h0,
    ST_RUN = 2'h1,
    ST_HUNG = 2'h2
  } boot_state_t;

endpackage : led_pkg

// ==== verilog/flash_divider.sv ====
// ----------------------------------------------------------------
// Programmable flash divider: square wave of given half period
// ----------------------------------------------------------------
module flash_divider (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // Half period in clock cycles
  input wire logic [25:0] half,
  // Square wave
  output logic phase
);

  // Cycles left in this half period
  logic [25:0] cnt_q;
  // Reload value, zero treated as one cycle
  logic [25:0] reload;

  assign reload = (half == 26'h0) ? 26'h0 : half - 26'h1;

  // Count down and toggle on reaching zero
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cnt_q <= 26'h0;
      phase <= 1'b0;
    end else if (ce) begin
      if (cnt_q == 26'h0) begin
        cnt_q <= reload;
        phase <= ~phase;
      end else if (cnt_q > reload) begin
        // Shorter period written: take it now, not after the long one
        cnt_q <= reload;
      end else begin
        cnt_q <= cnt_q - 26'h1;
      end
    end
  end

endmodule : flash_divider

// ==== verilog/diagnostic_led_status_encoder.sv ====
`include "led_defines.svh"

module diagnostic_led_status_encoder #(
  // Start-up watchdog length; shorten for simulation
  parameter logic [32:0] HANG_CYCLES = 33'(`LED_HANG_CYCLES)
) (
  // Clock, reset, enable
  input wire logic CLOCK,
  input wire logic RST_B,
  input wire logic CE,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Converter state
  input wire logic STARTED,
  input wire logic FW_UPDATING,
  input wire logic FW_WAIT_POWER,
  input wire logic FW_FAILED,
  input wire logic CARD_WRONG,
  input wire logic PARAM_WRONG,
  input wire logic FAULT_ACTIVE,
  input wire logic FACTORY_RESTORE,
  input wire logic [7:0] COMMISSIONING_STAGE,
  input wire logic [15:0] STATUS_WORD_ONE,
  input wire logic [31:0] MISSING_ENABLE_SIGNALS,
  // Fieldbus state
  input wire logic BUS_ACTIVE,
  input wire logic DATA_EXCHANGE,
  input wire logic BUS_CFG_FAULT,
  input wire logic DEVICE_NAMING,
  // Boot recovery
  input wire logic CARD_PRESENT,
  input wire logic [3:0] HUNG_BOOTS,
  input wire logic FLASH_DARK_HANG,
  input wire logic RECOVERING,
  input wire logic SAVE_RESTORE_STORED,
  // Indicators
  output logic RDY_RED,
  output logic RDY_GREEN,
  output logic BF_RED,
  output logic BF_GREEN,
  output logic LNK_GREEN,
  // Converter outputs
  output logic MOTOR_ENABLE,
  output logic BOOT_FAILURE_FAULT,
  output logic FACTORY_START,
  output logic SAVE_RESTORE_COMMAND
);

  // ----------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------
  logic [3:0] config_q; // Bus type, monitoring, save/restore
  logic [25:0] slow_q; // Slow half period
  logic [25:0] fast_q; // Fast half period
  logic [25:0] var_q; // Variable-rate half period
  led_pkg::boot_state_t boot_q; // Start-up sequence
  logic [32:0] hang_cnt_q; // Start-up watchdog
  logic hang_to_q; // Watchdog expired
  logic fact_done_q; // Factory flag sampled once

  led_pkg::fieldbus_t bus_type; // Decoded bus type
  logic mon_on; // Fieldbus monitoring active
  logic slow_ph; // Slow square wave
  logic fast_ph; // Fast square wave
  logic mid_ph; // Medium square wave
  logic var_ph; // Varying-rate wave

  assign bus_type = led_pkg::fieldbus_t'(config_q[`LED_CFG_BUS_LSB +: 2]);
  assign mon_on = config_q[`LED_CFG_MON_BIT];

  // ----------------------------------------------------------------
  // Flash rate generation
  // ----------------------------------------------------------------
  // Programmable slow rate
  flash_divider u_slow (
    .clk(CLOCK), .rst_b(RST_B), .ce(CE), .half(slow_q), .phase(slow_ph)
  );
  flash_divider u_fast (
    .clk(CLOCK), .rst_b(RST_B), .ce(CE), .half(fast_q), .phase(fast_ph)
  );
  // Third rate feeds the varying flash
  flash_divider u_mid (
    .clk(CLOCK), .rst_b(RST_B), .ce(CE), .half(var_q), .phase(mid_ph)
  );
  // Rate swaps each slow half period, so the eye sees it vary
  assign var_ph = slow_ph ? fast_ph : mid_ph;

  function automatic logic lvl(led_pkg::pattern_t p, logic s, logic f,
                               logic v);
    case (p)
      led_pkg::PAT_ON: lvl = 1'b1;
      led_pkg::PAT_SLOW: lvl = s;
      led_pkg::PAT_FAST: lvl = f;
      led_pkg::PAT_VAR: lvl = v;
      default: lvl = 1'b0;
    endcase
  endfunction : lvl

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  logic setup; // First cycle of a transfer
  logic access; // Completing access cycle
  logic hit; // Address is mapped
  logic [31:0] rd_val; // Read mux
  logic [31:0] status_val; // Live status word

  assign setup = PSEL & ~PENABLE;
  assign access = PSEL & PENABLE & PREADY;
  assign hit = (PADDR == `LED_CONFIG_OFS) | (PADDR == `LED_SLOW_OFS) |
               (PADDR == `LED_FAST_OFS) | (PADDR == `LED_VAR_OFS) |
               (PADDR == `LED_STATUS_OFS);

  // Read mux; unmapped reads as zero
  always_comb begin
    rd_val = 32'h0000_0000;
    case (PADDR)
      `LED_CONFIG_OFS: rd_val = {28'h000_0000, config_q};
      `LED_SLOW_OFS: rd_val = {6'h00, slow_q};
      `LED_FAST_OFS: rd_val = {6'h00, fast_q};
      `LED_VAR_OFS: rd_val = {6'h00, var_q};
      `LED_STATUS_OFS: rd_val = status_val;
      default: rd_val = 32'h0000_0000;
    endcase
  end

  // Answer in the cycle after setup: one wait-free access phase
  always_ff @(posedge CLOCK) begin
    if (!RST_B) begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h0000_0000;
    end else if (CE) begin
      PREADY <= setup;
      PSLVERR <= setup & ~hit;
      // Data captured at setup stays put through the access
      if (setup) begin
        PRDATA <= PWRITE ? 32'h0000_0000 : rd_val;
      end
    end
  end

  // Register writes take effect at the completing edge only
  always_ff @(posedge CLOCK) begin
    if (!RST_B) begin
      config_q <= `LED_CONFIG_RST;
      slow_q <= 26'(`LED_SLOW_HALF_MS * `LED_CYC_PER_MS);
      fast_q <= 26'(`LED_FAST_HALF_MS * `LED_CYC_PER_MS);
      var_q <= 26'(`LED_VAR_HALF_MS * `LED_CYC_PER_MS);
    end else if (CE && access && PWRITE) begin
      case (PADDR)
        `LED_CONFIG_OFS: config_q <= PWDATA[3:0];
        `LED_SLOW_OFS: slow_q <= PWDATA[25:0];
        `LED_FAST_OFS: fast_q <= PWDATA[25:0];
        `LED_VAR_OFS: var_q <= PWDATA[25:0];
        default: ; // Status is read-only, unmapped ignored
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Start-up sequence
  // ----------------------------------------------------------------
  // Orange until the converter reports started
  always_ff @(posedge CLOCK) begin
    if (!RST_B) begin
      boot_q <= led_pkg::ST_BOOT;
    end else if (CE) begin
      case (boot_q)
        led_pkg::ST_BOOT: begin
          if (STARTED) begin
            boot_q <= led_pkg::ST_RUN;
          end else if (hang_to_q) begin
            boot_q <= led_pkg::ST_HUNG;
          end
        end
        led_pkg::ST_HUNG: begin
          if (STARTED) begin
            boot_q <= led_pkg::ST_RUN;
          end
        end
        led_pkg::ST_RUN: boot_q <= led_pkg::ST_RUN;
        default: boot_q <= led_pkg::ST_BOOT;
      endcase
    end
  end

  // Watchdog on a start-up that never completes
  always_ff @(posedge CLOCK) begin
    if (!RST_B) begin
      hang_cnt_q <= 33'h0_0000_0000;
      hang_to_q <= 1'b0;
    end else if (CE && boot_q == led_pkg::ST_BOOT && !STARTED) begin
      if (hang_cnt_q >= HANG_CYCLES - 33'h1) begin
        hang_to_q <= 1'b1;
      end else begin
        hang_cnt_q <= hang_cnt_q + 33'h1;
      end
    end
  end

  // Stored save/restore seen once after reset release
  always_ff @(posedge CLOCK) begin
    if (!RST_B) begin
      fact_done_q <= 1'b0;
      FACTORY_START <= 1'b0;
    end else if (CE && !fact_done_q) begin
      fact_done_q <= 1'b1;
      FACTORY_START <= SAVE_RESTORE_STORED;
    end
  end

  // ----------------------------------------------------------------
  // Pattern selection
  // ----------------------------------------------------------------
  led_pkg::colour_t rdy_col, bf_col, lnk_col; // Colours
  led_pkg::pattern_t rdy_pat, bf_pat, lnk_pat; // Patterns
  led_pkg::colour_t bus_col; // Fieldbus bus-fault colour
  led_pkg::pattern_t bus_pat; // Fieldbus bus-fault pattern

  // Bus-fault indicator from the fieldbus alone
  always_comb begin
    bus_col = led_pkg::COL_NONE;
    bus_pat = led_pkg::PAT_OFF;
    case (bus_type)
      led_pkg::BUS_ETH, led_pkg::BUS_RS485: begin
        if (bus_type == led_pkg::BUS_RS485 && !mon_on) begin
          bus_pat = led_pkg::PAT_OFF;
        end else if (DATA_EXCHANGE) begin
          bus_pat = led_pkg::PAT_OFF;
        end else if (BUS_ACTIVE) begin
          bus_col = led_pkg::COL_RED;
          bus_pat = led_pkg::PAT_SLOW;
        end else begin
          bus_col = led_pkg::COL_RED;
          bus_pat = led_pkg::PAT_ON;
        end
      end
      led_pkg::BUS_TOKEN: begin
        if (!BUS_ACTIVE) begin
          bus_pat = led_pkg::PAT_OFF;
        end else if (DATA_EXCHANGE) begin
          bus_col = led_pkg::COL_GREEN;
          bus_pat = led_pkg::PAT_ON;
        end else if (BUS_CFG_FAULT) begin
          bus_col = led_pkg::COL_RED;
          bus_pat = led_pkg::PAT_SLOW;
        end else begin
          bus_col = led_pkg::COL_RED;
          bus_pat = led_pkg::PAT_FAST;
        end
      end
      default: begin
        bus_col = led_pkg::COL_NONE;
        bus_pat = led_pkg::PAT_OFF;
      end
    endcase
  end

  // Whole display; hang and boot displays override everything
  always_comb begin
    rdy_col = led_pkg::COL_GREEN;
    rdy_pat = led_pkg::PAT_ON;
    bf_col = bus_col;
    bf_pat = bus_pat;
    lnk_col = led_pkg::COL_GREEN;
    lnk_pat = led_pkg::PAT_OFF;
    if (bus_type == led_pkg::BUS_ETH) begin
      if (DEVICE_NAMING) begin
        lnk_pat = led_pkg::PAT_SLOW;
      end else if (DATA_EXCHANGE) begin
        lnk_pat = led_pkg::PAT_ON;
      end
    end
    if (FLASH_DARK_HANG || boot_q == led_pkg::ST_HUNG) begin
      // Hang displays: orange recovery, dark cycles, flicker
      rdy_col = led_pkg::COL_ORANGE;
      bf_col = led_pkg::COL_ORANGE;
      lnk_col = led_pkg::COL_ORANGE;
      rdy_pat = RECOVERING ? led_pkg::PAT_FAST : led_pkg::PAT_SLOW;
      if (!FLASH_DARK_HANG) begin
        rdy_pat = led_pkg::PAT_FAST;
      end
      bf_pat = rdy_pat;
      lnk_pat = rdy_pat;
    end else if (boot_q == led_pkg::ST_BOOT) begin
      rdy_col = led_pkg::COL_ORANGE;
      bf_pat = led_pkg::PAT_OFF;
      lnk_pat = led_pkg::PAT_OFF;
    end else if (FW_UPDATING) begin
      rdy_col = led_pkg::COL_RED;
      bf_col = led_pkg::COL_ORANGE;
      bf_pat = led_pkg::PAT_VAR;
    end else if (FW_WAIT_POWER) begin
      rdy_col = led_pkg::COL_RED;
      rdy_pat = led_pkg::PAT_SLOW;
      bf_col = led_pkg::COL_RED;
      bf_pat = led_pkg::PAT_SLOW;
    end else if (CARD_WRONG ||
                 (PARAM_WRONG && bus_type == led_pkg::BUS_RS485)) begin
      rdy_col = led_pkg::COL_RED;
      rdy_pat = led_pkg::PAT_FAST;
      bf_col = led_pkg::COL_RED;
      bf_pat = led_pkg::PAT_FAST;
    end else if (FW_FAILED) begin
      rdy_col = led_pkg::COL_RED;
      rdy_pat = led_pkg::PAT_FAST;
      bf_col = led_pkg::COL_RED;
      bf_pat = led_pkg::PAT_ON;
    end else if (FAULT_ACTIVE) begin
      // Active fault; bus-fault keeps the bus view
      rdy_col = led_pkg::COL_RED;
      rdy_pat = led_pkg::PAT_FAST;
    end else if (COMMISSIONING_STAGE != 8'h00 || FACTORY_RESTORE) begin
      rdy_pat = led_pkg::PAT_SLOW;
    end
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  logic rdy_on, bf_on, lnk_on; // Lamp levels this cycle

  assign rdy_on = lvl(rdy_pat, slow_ph, fast_ph, var_ph);
  assign bf_on = lvl(bf_pat, slow_ph, fast_ph, var_ph);
  assign lnk_on = lvl(lnk_pat, slow_ph, fast_ph, var_ph);

  // Lamps and converter flags, one cycle behind their causes
  always_ff @(posedge CLOCK) begin
    if (!RST_B) begin
      RDY_RED <= 1'b0;
      RDY_GREEN <= 1'b0;
      BF_RED <= 1'b0;
      BF_GREEN <= 1'b0;
      LNK_GREEN <= 1'b0;
      MOTOR_ENABLE <= 1'b0;
      BOOT_FAILURE_FAULT <= 1'b0;
      SAVE_RESTORE_COMMAND <= 1'b0;
    end else if (CE) begin
      RDY_RED <= rdy_on & rdy_col[0];
      RDY_GREEN <= rdy_on & rdy_col[1];
      BF_RED <= bf_on & bf_col[0];
      BF_GREEN <= bf_on & bf_col[1];
      LNK_GREEN <= lnk_on & lnk_col[1];
      MOTOR_ENABLE <= !FAULT_ACTIVE && COMMISSIONING_STAGE == 8'h00 &&
                      STATUS_WORD_ONE[0] &&
                      MISSING_ENABLE_SIGNALS == 32'h0000_0000;
      // Repeated hung boots with no card
      BOOT_FAILURE_FAULT <= !CARD_PRESENT &&
                            HUNG_BOOTS >= `LED_BOOT_FAIL_TRIES;
      // Save/restore request toward the settings store
      SAVE_RESTORE_COMMAND <= config_q[`LED_CFG_SAVE_BIT];
    end
  end

  // Status word for software
  always_comb begin
    status_val = 32'h0000_0000;
    status_val[`LED_ST_RUN_BIT] = (boot_q == led_pkg::ST_RUN);
    status_val[`LED_ST_BOOTF_BIT] = BOOT_FAILURE_FAULT;
    status_val[`LED_ST_MOTOR_BIT] = MOTOR_ENABLE;
    status_val[`LED_ST_FACT_BIT] = FACTORY_START;
    status_val[`LED_ST_HANG_BIT] = hang_to_q;
    status_val[`LED_ST_RDY_LSB +: 2] = {RDY_GREEN, RDY_RED};
    status_val[`LED_ST_BF_LSB +: 2] = {BF_GREEN, BF_RED};
    status_val[`LED_ST_LNK_BIT] = LNK_GREEN;
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_setup;
    PSEL && !PENABLE && CE;
  endsequence
  sequence s_access;
    PSEL && PENABLE && PREADY;
  endsequence

  a_apb_answer: assert property (@(posedge CLOCK) disable iff (!RST_B)
    s_setup |=> PREADY)
    else $error("APB answer not one cycle after setup");
  a_cfg_write: assert property (@(posedge CLOCK) disable iff (!RST_B)
    (s_access and (CE && PWRITE && PADDR == `LED_CONFIG_OFS)) |=>
      config_q == $past(PWDATA[3:0]))
    else $error("Config write lost");
  a_boot_orange: assert property (@(posedge CLOCK) disable iff (!RST_B)
    (CE && boot_q == led_pkg::ST_BOOT && !FLASH_DARK_HANG) |=>
      RDY_RED && RDY_GREEN)
    else $error("Ready not orange during start-up");
  a_fw_update: assert property (@(posedge CLOCK) disable iff (!RST_B)
    (CE && boot_q == led_pkg::ST_RUN && !FLASH_DARK_HANG && FW_UPDATING)
      |=> RDY_RED && !RDY_GREEN)
    else $error("Ready not steady red in update");
  a_power_wait: assert property (@(posedge CLOCK) disable iff (!RST_B)
    (CE && boot_q == led_pkg::ST_RUN && !FLASH_DARK_HANG && !FW_UPDATING
      && FW_WAIT_POWER) |=> RDY_RED == BF_RED && !RDY_GREEN)
    else $error("Power-cycle wait pattern wrong");
  a_fw_failed: assert property (@(posedge CLOCK) disable iff (!RST_B)
    (CE && boot_q == led_pkg::ST_RUN && !FLASH_DARK_HANG && !FW_UPDATING
      && !FW_WAIT_POWER && !CARD_WRONG && !PARAM_WRONG && FW_FAILED)
      |=> BF_RED && !BF_GREEN)
    else $error("Bus-fault not lit on failed update");
  a_no_fault: assert property (@(posedge CLOCK) disable iff (!RST_B)
    (CE && boot_q == led_pkg::ST_RUN && !FLASH_DARK_HANG && !FW_UPDATING
      && !FW_WAIT_POWER && !CARD_WRONG && !PARAM_WRONG && !FW_FAILED &&
      !FAULT_ACTIVE && COMMISSIONING_STAGE == 8'h00 && !FACTORY_RESTORE)
      |=> RDY_GREEN && !RDY_RED)
    else $error("Ready not steady green without fault");
  a_monitor_off: assert property (@(posedge CLOCK) disable iff (!RST_B)
    (CE && boot_q == led_pkg::ST_RUN && !FLASH_DARK_HANG && !FW_UPDATING
      && !FW_WAIT_POWER && !CARD_WRONG && !FW_FAILED &&
      bus_type == led_pkg::BUS_RS485 && !mon_on && !PARAM_WRONG)
      |=> !BF_RED && !BF_GREEN)
    else $error("Bus-fault lit with monitoring off");
  a_link_off: assert property (@(posedge CLOCK) disable iff (!RST_B)
    (CE && bus_type != led_pkg::BUS_ETH && !FLASH_DARK_HANG &&
      boot_q != led_pkg::ST_HUNG) |=> !LNK_GREEN)
    else $error("Link lit on non-Ethernet bus");
  a_motor_gate: assert property (@(posedge CLOCK) disable iff (!RST_B)
    (CE && (FAULT_ACTIVE || !STATUS_WORD_ONE[0])) |=> !MOTOR_ENABLE)
    else $error("Motor enabled against interlock");

endmodule : diagnostic_led_status_encoder

// ==== verification/led_observer.sv ====
// ----------------------------------------------------------
// Operator view: colour seen on each two-die indicator
// ----------------------------------------------------------
module led_observer (
  // Ready lamp dies
  input wire logic rdy_red,
  input wire logic rdy_green,
  // Bus-fault lamp dies
  input wire logic bf_red,
  input wire logic bf_green,
  // Perceived colours
  output led_pkg::colour_t rdy_col,
  output led_pkg::colour_t bf_col
);
  timeunit 1ns;
  timeprecision 1ps;
  // Both dies lit blend to orange or yellow for the eye
  assign rdy_col = led_pkg::colour_t'({rdy_green, rdy_red});
  assign bf_col = led_pkg::colour_t'({bf_green, bf_red});
endmodule : led_observer

// ==== verification/tb_top.sv ====
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------
  // Signals named as the design ports
  // ----------------------------------------------------------
  logic CLOCK, RST_B, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
  logic STARTED, FW_UPDATING, FW_WAIT_POWER, FW_FAILED, CARD_WRONG;
  logic FAULT_ACTIVE, BUS_ACTIVE, DATA_EXCHANGE, BUS_CFG_FAULT, PARAM_WRONG;
  logic DEVICE_NAMING, CARD_PRESENT, SAVE_RESTORE_STORED;
  logic RDY_RED, RDY_GREEN, BF_RED, BF_GREEN, LNK_GREEN, MOTOR_ENABLE;
  logic BOOT_FAILURE_FAULT, FACTORY_START, SAVE_RESTORE_COMMAND;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, PRDATA, MISSING_ENABLE_SIGNALS;
  logic [7:0] COMMISSIONING_STAGE;
  logic [15:0] STATUS_WORD_ONE;
  logic [3:0] HUNG_BOOTS;
  // Expected read results, oldest first
  logic [31:0] exp_q[$], msk_q[$];
  logic err_q[$];
  led_pkg::colour_t rdy_col;
  int fails, checks_done;
  wire [4:0] lamps = {LNK_GREEN, BF_GREEN, BF_RED, RDY_GREEN, RDY_RED};

  // Unused option inputs tied low; clock enable held on
  diagnostic_led_status_encoder #(.HANG_CYCLES(33'h0_0000_00C8)) u_dut (
    .*, .CE(1'b1), .FACTORY_RESTORE(1'b0),
    .FLASH_DARK_HANG(1'b0), .RECOVERING(1'b0));
  led_observer u_eye (.rdy_red(RDY_RED), .rdy_green(RDY_GREEN),
    .bf_red(BF_RED), .bf_green(BF_GREEN), .rdy_col(rdy_col), .bf_col());

  initial begin
    CLOCK = 1'b0;
    forever #12.5 CLOCK = ~CLOCK;
  end

  task automatic chk(input string nm, input logic [31:0] e, s);
    checks_done++;
    if (e !== s) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  // APB master: holds the request until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    {PSEL, PENABLE, PWRITE, PADDR, PWDATA} <= {2'b10, wr, a, d};
    @(posedge CLOCK);
    PENABLE <= 1'b1;
    // Only the watchdog ends a wait that never sees pready
    do @(posedge CLOCK);
    while (PREADY !== 1'b1);
    {PSEL, PENABLE} <= 2'b00;
    // Idle edge so the next call never reassigns in this time step
    @(posedge CLOCK);
  endtask : apb

  task automatic rd(input logic [11:0] a, input logic [31:0] m, e,
                    input logic er);
    exp_q.push_back(e);
    msk_q.push_back(m);
    err_q.push_back(er);
    apb(1'b0, a, 32'h0000_0000);
  endtask : rd

  // Lamps settle a cycle after inputs; status read a little later
  task automatic look(input logic [31:0] m, e);
    repeat (3) @(posedge CLOCK);
    rd(12'h010, m, e, 1'b0);
  endtask : look

  // Toggle count over 40 cycles tells fast, slow and steady apart
  task automatic flash(input int i, input int half);
    int n;
    logic p;
    n = 0;
    p = lamps[i];
    repeat (40) begin
      @(posedge CLOCK);
      n += int'(lamps[i] !== p);
      p = lamps[i];
    end
    chk("toggles", 32'(n > 40 / half - 3 && n < 40 / half + 2), 32'h1);
  endtask : flash

  // Read monitor compares against the oldest note
  always @(posedge CLOCK) begin
    if (PSEL && PENABLE && PREADY === 1'b1 && PWRITE === 1'b0) begin
      chk("rdata", exp_q.pop_front(), PRDATA & msk_q.pop_front());
      chk("slverr", 32'(err_q.pop_front()), 32'(PSLVERR));
    end
  end

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_sim

  initial begin
    {RST_B, PSEL, PENABLE, PWRITE, PADDR, PWDATA, STARTED, FW_UPDATING,
     FW_WAIT_POWER, FW_FAILED, CARD_WRONG, FAULT_ACTIVE, BUS_ACTIVE,
     DATA_EXCHANGE, BUS_CFG_FAULT, DEVICE_NAMING, SAVE_RESTORE_STORED,
     PARAM_WRONG,
     COMMISSIONING_STAGE, MISSING_ENABLE_SIGNALS, HUNG_BOOTS} = '0;
    CARD_PRESENT = 1'b1;
    STATUS_WORD_ONE = 16'h0001;
    void'($urandom(21));
    repeat (12) @(posedge CLOCK);
    RST_B <= 1'b1;
    repeat (2) @(posedge CLOCK);
    chk("start colour", 32'(led_pkg::COL_ORANGE), 32'(rdy_col));
    rd(12'h000, 32'hFFFF_FFFF, 32'h0000_0004, 1'b0);
    rd(12'h020, 32'hFFFF_FFFF, 32'h0000_0000, 1'b1);
    apb(1'b1, 12'h004, 32'h0000_0004);
    apb(1'b1, 12'h008, 32'h0000_0002);
    apb(1'b1, 12'h00C, 32'h0000_0003);
    STARTED <= 1'b1;
    look(32'h0000_0307, 32'h0000_0205);
    MISSING_ENABLE_SIGNALS <= $urandom | 32'h0000_0001;
    look(32'h0000_0004, 32'h0000_0000);
    {MISSING_ENABLE_SIGNALS, FAULT_ACTIVE} <= 33'h0_0000_0001;
    flash(0, 2);
    FAULT_ACTIVE <= 1'b0;
    COMMISSIONING_STAGE <= 8'($urandom_range(255, 1));
    flash(1, 4);
    {COMMISSIONING_STAGE, FAULT_ACTIVE, FW_WAIT_POWER} <= 10'h003;
    flash(2, 4);
    flash(0, 4);
    {FW_WAIT_POWER, CARD_WRONG} <= 2'b01;
    flash(2, 2);
    {CARD_WRONG, FW_FAILED} <= 2'b01;
    look(32'h0000_0C00, 32'h0000_0400);
    FW_UPDATING <= 1'b1;
    look(32'h0000_0300, 32'h0000_0100);
    {FAULT_ACTIVE, FW_FAILED, FW_UPDATING, BUS_ACTIVE} <= 4'h1;
    $display("test ready lamp done");
    DATA_EXCHANGE <= 1'b1;
    look(32'h0000_1000, 32'h0000_1000);
    DEVICE_NAMING <= 1'b1;
    flash(4, 4);
    {DATA_EXCHANGE, DEVICE_NAMING} <= 2'b00;
    flash(2, 4);
    BUS_ACTIVE <= 1'b0;
    apb(1'b1, 12'h000, 32'h0000_0005);
    look(32'h0000_1C00, 32'h0000_0400);
    {BUS_ACTIVE, DATA_EXCHANGE} <= 2'b11;
    look(32'h0000_0C00, 32'h0000_0000);
    PARAM_WRONG <= 1'b1;
    flash(2, 2);
    flash(0, 2);
    {BUS_ACTIVE, DATA_EXCHANGE, PARAM_WRONG} <= 3'b000;
    apb(1'b1, 12'h000, 32'h0000_0001);
    look(32'h0000_0C00, 32'h0000_0000);
    apb(1'b1, 12'h000, 32'h0000_0006);
    {BUS_ACTIVE, DATA_EXCHANGE} <= 2'b11;
    look(32'h0000_0C00, 32'h0000_0800);
    {DATA_EXCHANGE, BUS_CFG_FAULT} <= 2'b01;
    flash(2, 4);
    BUS_CFG_FAULT <= 1'b0;
    flash(2, 2);
    BUS_ACTIVE <= 1'b0;
    look(32'h0000_0C00, 32'h0000_0000);
    $display("test fieldbus done");
    {CARD_PRESENT, HUNG_BOOTS} <= 5'h03;
    look(32'h0000_0002, 32'h0000_0002);
    HUNG_BOOTS <= 4'h2;
    look(32'h0000_0002, 32'h0000_0000);
    apb(1'b1, 12'h000, 32'h0000_0008);
    repeat (2) @(posedge CLOCK);
    chk("save cmd", 32'h0000_0001, 32'(SAVE_RESTORE_COMMAND));
    {SAVE_RESTORE_STORED, STARTED, RST_B} <= 3'b100;
    repeat (2) @(posedge CLOCK);
    RST_B <= 1'b1;
    look(32'h0000_0008, 32'h0000_0008);
    repeat (220) @(posedge CLOCK);
    look(32'h0000_0011, 32'h0000_0010);
    $display("test boot recovery done");
    end_sim();
  end

  initial begin
    repeat (5000) @(posedge CLOCK);
    fails++;
    end_sim();
  end
endmodule : tb_top
